// file: logic/uccb_serial_port.sv
// Serial port: APB registers, line format, transmitter, receiver, request lines
// Functional notes
// [RULE1] Length bit picks eight or seven data bits
// [RULE2] Parity enable adds and checks parity bit
// [RULE3] Parity type: one odd, zero even
// [RULE4] Stop length bit picks two or one
// [RULE5] Always exactly one start bit
// [RULE6] Transmit-complete request when enabled
// [RULE7] Receive-error request when enabled
// [RULE8] Receive-full request at threshold when enabled
// [RULE9] Threshold: one or two characters held
// [RULE10] Transmit-empty request when shifting begins
// [RULE11] Transfers only while port enabled
// [RULE12] Disabling discards transmit buffer content
// [RULE13] Software configures only while port disabled
// [RULE14] Infrared select switches infrared function
// [RULE15] Counter reloads, counts to underflow
// [RULE16] Rate is clock over 16(reload+1)+fine
// [RULE17] Reserved bits read zero, ignore writes
// [RULE18] Least significant bit first, one is high
// [RULE19] Seven-bit mode stores top bit zero
// [RULE20] Parity checked when moving into buffer
// [RULE21] Each delay adds one count clock
// [RULE22] Parity bit between data and stops
// [RULE23] Request equals enable AND condition flag
`timescale 1ns/1ps
module uccb_serial_port
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [uccb_pkg::ADDR_W-1:0] paddr,
	input wire logic [uccb_pkg::DATA_W-1:0] pwdata,
	output logic [uccb_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic irq_tx_complete,
	output logic irq_rx_error,
	output logic irq_rx_full,
	output logic irq_tx_empty
);
	typedef struct packed
	{
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [7:0] fmt;
		logic [7:0] ctl;
		logic [7:0] irs;
		logic [7:0] rate;
		logic [7:0] fine;
		logic [7:0] txbuf;
		logic tdbe;
		logic tred;
		logic fer;
		logic per;
		logic oer;
		logic [7:0] rxb0;
		logic [7:0] rxb1;
		logic [1:0] rxcnt;
		uccb_pkg::uccb_frame_state_t tx_st;
		logic [3:0] tx_sub;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_par;
		logic tx_stop2;
		logic trbs;
		uccb_pkg::uccb_frame_state_t rx_st;
		logic [3:0] rx_sub;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_par;
		logic sync1;
		logic sync2;
		logic [3:0] ir_hold;
		logic sout;
		logic irq_tc;
		logic irq_re;
		logic irq_rf;
		logic irq_te;
	} uccb_port_state_t;

	uccb_port_state_t r;
	uccb_port_state_t n;
	uccb_pkg::uccb_baud_cfg_t baud_cfg;
	logic tick;
	logic acc;
	logic setup_done;
	logic mapped;
	logic [7:0] rd_mux;
	logic [2:0] last_bit;
	logic line_bit;
	logic rx_line;
	logic [7:0] rx_word;

	function automatic logic hit(input logic [uccb_pkg::ADDR_W-1:0] a, input logic [15:0] idx);
		hit = (a == uccb_pkg::ADDR_W'({idx, 2'b00}));
	endfunction

	// Parity of the data bits that actually travel
	function automatic logic parity_of(input logic [7:0] d, input logic eight, input logic odd);
		logic [7:0] m;
		m = eight ? d : {1'b0, d[6:0]};
		parity_of = (^m) ^ odd; // [RULE3]
	endfunction

	assign baud_cfg.run = r.ctl[uccb_pkg::CTL_PORT_EN]; // [RULE11]
	assign baud_cfg.reload = r.rate;
	assign baud_cfg.fine = r.fine[3:0];

	uccb_baud_gen u_baud
	(
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.cfg(baud_cfg),
		.tick(tick)
	);

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign serial_out_pin = r.sout;
	assign irq_tx_complete = r.irq_tc;
	assign irq_rx_error = r.irq_re;
	assign irq_rx_full = r.irq_rf;
	assign irq_tx_empty = r.irq_te;

	always_comb
	begin
		n = r;
		acc = psel & penable & r.pready;
		setup_done = psel & penable & ~r.pready;
		mapped = 1'b0;
		rd_mux = '0;
		// Defaulted here so the receive path never infers a latch
		rx_word = '0;
		if (hit(paddr, uccb_pkg::IDX_STATUS))
		begin
			mapped = 1'b1;
			rd_mux = {r.tred, r.fer, r.per, r.oer, r.rxcnt == uccb_pkg::RX_DEPTH, r.trbs, r.rxcnt != '0, r.tdbe};
		end
		if (hit(paddr, uccb_pkg::IDX_TXDATA))
		begin
			mapped = 1'b1;
			rd_mux = r.txbuf;
		end
		if (hit(paddr, uccb_pkg::IDX_RXDATA))
		begin
			mapped = 1'b1;
			rd_mux = r.rxb0;
		end
		if (hit(paddr, uccb_pkg::IDX_FORMAT))
		begin
			mapped = 1'b1;
			rd_mux = r.fmt;
		end
		if (hit(paddr, uccb_pkg::IDX_CTRL))
		begin
			mapped = 1'b1;
			rd_mux = r.ctl;
		end
		if (hit(paddr, uccb_pkg::IDX_IRSEL))
		begin
			mapped = 1'b1;
			rd_mux = r.irs;
		end
		if (hit(paddr, uccb_pkg::IDX_RATE))
		begin
			mapped = 1'b1;
			rd_mux = r.rate;
		end
		if (hit(paddr, uccb_pkg::IDX_FINE))
		begin
			mapped = 1'b1;
			rd_mux = r.fine;
		end

		// One wait state: data and error are registered on the same edge as pready
		n.pready = setup_done;
		n.pslverr = setup_done & ~mapped;
		if (setup_done)
			n.prdata = uccb_pkg::DATA_W'(rd_mux);

		if (acc && pwrite && !r.pslverr)
		begin
			if (hit(paddr, uccb_pkg::IDX_FORMAT))
				n.fmt = pwdata[7:0] & uccb_pkg::FORMAT_WMASK; // [RULE17]
			if (hit(paddr, uccb_pkg::IDX_IRSEL))
				n.irs = pwdata[7:0] & uccb_pkg::IRSEL_WMASK; // [RULE17]
			if (hit(paddr, uccb_pkg::IDX_RATE))
				n.rate = pwdata[7:0] & uccb_pkg::RATE_WMASK;
			if (hit(paddr, uccb_pkg::IDX_FINE))
				n.fine = pwdata[7:0] & uccb_pkg::FINE_WMASK; // [RULE17]
			if (hit(paddr, uccb_pkg::IDX_TXDATA))
			begin
				n.txbuf = pwdata[7:0];
				n.tdbe = 1'b0;
			end
			if (hit(paddr, uccb_pkg::IDX_CTRL))
			begin
				n.ctl = pwdata[7:0] & uccb_pkg::CTRL_WMASK; // [RULE17]
				if (!pwdata[uccb_pkg::CTL_PORT_EN])
					n.tdbe = 1'b1; // [RULE12]
			end
			if (hit(paddr, uccb_pkg::IDX_STATUS))
			begin
				// Clears come first so a same-cycle event below wins
				n.tred = r.tred & ~pwdata[uccb_pkg::ST_TX_DONE];
				n.fer = r.fer & ~pwdata[uccb_pkg::ST_FRAME_ERR];
				n.per = r.per & ~pwdata[uccb_pkg::ST_PARITY_ERR];
				n.oer = r.oer & ~pwdata[uccb_pkg::ST_OVERRUN];
			end
		end

		// Reading the oldest character releases its slot
		if (acc && !pwrite && !r.pslverr && hit(paddr, uccb_pkg::IDX_RXDATA) && (r.rxcnt != '0))
		begin
			n.rxb0 = r.rxb1;
			n.rxcnt = r.rxcnt - 2'h1;
		end

		last_bit = r.fmt[uccb_pkg::FMT_CHAR_LEN] ? uccb_pkg::LAST_BIT_8 : uccb_pkg::LAST_BIT_7; // [RULE1]

		// Infrared receive: a short high pulse marks a zero, stretched over a bit
		if (tick)
		begin
			if (r.sync2)
				n.ir_hold = uccb_pkg::TICK_LAST;
			else if (r.ir_hold != '0)
				n.ir_hold = r.ir_hold - 4'h1;
		end
		rx_line = r.irs[uccb_pkg::IRS_INFRARED] ? ~(r.sync2 | (r.ir_hold != '0)) : r.sync2; // [RULE14]

		if (!r.ctl[uccb_pkg::CTL_PORT_EN])
		begin
			// Frames in flight are abandoned
			n.tx_st = uccb_pkg::FR_IDLE; // [RULE11]
			n.rx_st = uccb_pkg::FR_IDLE;
			n.trbs = 1'b0;
		end
		else if (tick)
		begin
			n.tx_sub = r.tx_sub + 4'h1;
			unique case (r.tx_st)
				uccb_pkg::FR_IDLE:
				begin
					n.tx_sub = '0;
					if (!r.tdbe)
					begin
						n.tx_sh = r.txbuf;
						n.tx_par = parity_of(r.txbuf, r.fmt[uccb_pkg::FMT_CHAR_LEN], r.fmt[uccb_pkg::FMT_PAR_ODD]);
						n.tdbe = 1'b1; // [RULE10]
						n.trbs = 1'b1;
						n.tx_stop2 = 1'b0;
						n.tx_st = uccb_pkg::FR_START;
					end
				end
				uccb_pkg::FR_START:
					if (r.tx_sub == uccb_pkg::TICK_LAST)
					begin
						n.tx_bit = '0;
						n.tx_st = uccb_pkg::FR_DATA; // [RULE5]
					end
				uccb_pkg::FR_DATA:
					if (r.tx_sub == uccb_pkg::TICK_LAST)
					begin
						n.tx_bit = r.tx_bit + 3'h1;
						if (r.tx_bit == last_bit)
							n.tx_st = r.fmt[uccb_pkg::FMT_PAR_EN] ? uccb_pkg::FR_PARITY : uccb_pkg::FR_STOP; // [RULE22]
					end
				uccb_pkg::FR_PARITY:
					if (r.tx_sub == uccb_pkg::TICK_LAST)
						n.tx_st = uccb_pkg::FR_STOP;
				uccb_pkg::FR_STOP:
					if (r.tx_sub == uccb_pkg::TICK_LAST)
					begin
						n.tx_stop2 = 1'b1;
						if (r.tx_stop2 || !r.fmt[uccb_pkg::FMT_STOP_LEN]) // [RULE4]
						begin
							n.tx_st = uccb_pkg::FR_IDLE;
							n.trbs = 1'b0;
							n.tred = 1'b1; // [RULE6]
						end
					end
				default:
					n.tx_st = uccb_pkg::FR_IDLE;
			endcase

			n.rx_sub = r.rx_sub + 4'h1;
			unique case (r.rx_st)
				uccb_pkg::FR_IDLE:
				begin
					n.rx_sub = '0;
					if (!rx_line)
						n.rx_st = uccb_pkg::FR_START;
				end
				uccb_pkg::FR_START:
					if (r.rx_sub == uccb_pkg::TICK_MID)
					begin
						// A glitch shorter than half a bit is no start bit
						n.rx_sub = '0;
						n.rx_bit = '0;
						n.rx_sh = '0;
						n.rx_st = rx_line ? uccb_pkg::FR_IDLE : uccb_pkg::FR_DATA; // [RULE5]
					end
				uccb_pkg::FR_DATA:
					if (r.rx_sub == uccb_pkg::TICK_LAST)
					begin
						n.rx_sh[r.rx_bit] = rx_line; // [RULE18]
						n.rx_bit = r.rx_bit + 3'h1;
						if (r.rx_bit == last_bit)
							n.rx_st = r.fmt[uccb_pkg::FMT_PAR_EN] ? uccb_pkg::FR_PARITY : uccb_pkg::FR_STOP; // [RULE22]
					end
				uccb_pkg::FR_PARITY:
					if (r.rx_sub == uccb_pkg::TICK_LAST)
					begin
						n.rx_par = rx_line;
						n.rx_st = uccb_pkg::FR_STOP;
					end
				uccb_pkg::FR_STOP:
					if (r.rx_sub == uccb_pkg::TICK_LAST)
					begin
						// Receiver checks one stop bit and re-arms for the next start
						n.rx_st = uccb_pkg::FR_IDLE;
						rx_word = r.fmt[uccb_pkg::FMT_CHAR_LEN] ? r.rx_sh : {1'b0, r.rx_sh[6:0]}; // [RULE19]
						if (!rx_line)
							n.fer = 1'b1; // [RULE7]
						if (n.rxcnt == uccb_pkg::RX_DEPTH)
							n.oer = 1'b1; // [RULE7]
						else
						begin
							if (r.fmt[uccb_pkg::FMT_PAR_EN] && (r.rx_par != parity_of(rx_word,
								r.fmt[uccb_pkg::FMT_CHAR_LEN], r.fmt[uccb_pkg::FMT_PAR_ODD])))
								n.per = 1'b1; // [RULE20] [RULE2]
							if (n.rxcnt == '0)
								n.rxb0 = rx_word;
							else
								n.rxb1 = rx_word;
							n.rxcnt = n.rxcnt + 2'h1;
						end
					end
				default:
					n.rx_st = uccb_pkg::FR_IDLE;
			endcase
		end

		// Line level follows the frame position of this cycle
		unique case (r.tx_st)
			uccb_pkg::FR_START:
				line_bit = 1'b0;
			uccb_pkg::FR_DATA:
				line_bit = r.tx_sh[r.tx_bit]; // [RULE18]
			uccb_pkg::FR_PARITY:
				line_bit = r.tx_par; // [RULE2]
			default:
				line_bit = 1'b1;
		endcase
		// Infrared sends a short high pulse for each zero and stays low otherwise
		if (r.irs[uccb_pkg::IRS_INFRARED])
			n.sout = ~line_bit & (r.tx_sub < uccb_pkg::IR_PULSE_TICKS); // [RULE14]
		else
			n.sout = line_bit;

		n.sync1 = serial_in_pin;
		n.sync2 = r.sync1;

		n.irq_tc = n.ctl[uccb_pkg::CTL_TX_DONE_IE] & n.tred; // [RULE23] [RULE6]
		n.irq_re = n.ctl[uccb_pkg::CTL_RX_ERR_IE] & (n.fer | n.per | n.oer); // [RULE23] [RULE7]
		n.irq_rf = n.ctl[uccb_pkg::CTL_RX_FULL_IE] & (n.ctl[uccb_pkg::CTL_RX_THRESH] ?
			(n.rxcnt == uccb_pkg::RX_DEPTH) : (n.rxcnt != '0)); // [RULE8] [RULE9]
		n.irq_te = n.ctl[uccb_pkg::CTL_TX_EMPTY_IE] & n.tdbe; // [RULE23] [RULE10]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
			r.fmt <= uccb_pkg::REG_RST;
			r.ctl <= uccb_pkg::REG_RST;
			r.irs <= uccb_pkg::REG_RST;
			r.rate <= uccb_pkg::REG_RST;
			r.fine <= uccb_pkg::REG_RST;
			r.tdbe <= 1'b1;
			r.sync1 <= 1'b1;
			r.sync2 <= 1'b1;
			r.sout <= 1'b1;
		end
		else if (clk_en)
			r <= n;
	end
endmodule // uccb_serial_port

// file: logic/uccb_pkg.sv
// Shared constants, field layouts and carrier types of the serial port block
package uccb_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_STATUS = 16'h4100;
	localparam logic [15:0] IDX_TXDATA = 16'h4101;
	localparam logic [15:0] IDX_RXDATA = 16'h4102;
	localparam logic [15:0] IDX_FORMAT = 16'h4103;
	localparam logic [15:0] IDX_CTRL = 16'h4104;
	localparam logic [15:0] IDX_IRSEL = 16'h4105;
	localparam logic [15:0] IDX_RATE = 16'h4106;
	localparam logic [15:0] IDX_FINE = 16'h4107;

	// serial_line_format fields
	localparam int FMT_CHAR_LEN = 4;
	localparam int FMT_PAR_EN = 3;
	localparam int FMT_PAR_ODD = 2;
	localparam int FMT_STOP_LEN = 1;
	// serial_control_irq_enable fields
	localparam int CTL_TX_DONE_IE = 7;
	localparam int CTL_RX_ERR_IE = 6;
	localparam int CTL_RX_FULL_IE = 5;
	localparam int CTL_TX_EMPTY_IE = 4;
	localparam int CTL_RX_THRESH = 1;
	localparam int CTL_PORT_EN = 0;
	// serial_infrared_select field
	localparam int IRS_INFRARED = 0;
	// Status fields
	localparam int ST_TX_DONE = 7;
	localparam int ST_FRAME_ERR = 6;
	localparam int ST_PARITY_ERR = 5;
	localparam int ST_OVERRUN = 4;
	localparam int ST_RX_TWO = 3;
	localparam int ST_TX_BUSY = 2;
	localparam int ST_RX_READY = 1;
	localparam int ST_TX_EMPTY = 0;

	// Writable bits; all others are reserved
	localparam logic [7:0] FORMAT_WMASK = 8'h1e;
	localparam logic [7:0] CTRL_WMASK = 8'hf3;
	localparam logic [7:0] IRSEL_WMASK = 8'h01;
	localparam logic [7:0] RATE_WMASK = 8'hff;
	localparam logic [7:0] FINE_WMASK = 8'h0f;
	localparam logic [7:0] REG_RST = 8'h00;

	// Oversampling: sixteen ticks per bit
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
	localparam logic [2:0] LAST_BIT_8 = 3'h7;
	localparam logic [2:0] LAST_BIT_7 = 3'h6;
	localparam logic [1:0] RX_DEPTH = 2'h2;

	// Insertion rank of each underflow slot, slot 0 in the low nibble
	localparam logic [63:0] FINE_RANK = 64'h084c2a6e195d3b7f;

	typedef enum logic [2:0]
	{
		FR_IDLE = 3'b000,
		FR_START = 3'b001,
		FR_DATA = 3'b011,
		FR_PARITY = 3'b010,
		FR_STOP = 3'b110
	} uccb_frame_state_t;

	typedef struct packed
	{
		logic run;
		logic [7:0] reload;
		logic [3:0] fine;
	} uccb_baud_cfg_t;
endpackage

// file: logic/uccb_baud_gen.sv
// Baud rate generator: reload down-counter with fine delay insertion
`timescale 1ns/1ps
module uccb_baud_gen
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input uccb_pkg::uccb_baud_cfg_t cfg,
	output logic tick
);
	typedef struct packed
	{
		logic [7:0] cnt;
		logic [3:0] slot;
		logic delayed;
		logic tick;
	} uccb_baud_state_t;

	uccb_baud_state_t r;
	uccb_baud_state_t n;
	logic [3:0] rank;

	assign tick = r.tick;

	always_comb
	begin
		n = r;
		n.tick = 1'b0;
		rank = uccb_pkg::FINE_RANK[{r.slot, 2'b00} +: 4];
		if (!cfg.run)
		begin
			n.cnt = cfg.reload;
			n.slot = '0;
			n.delayed = 1'b0;
		end
		else if (r.cnt != '0)
			n.cnt = r.cnt - 8'h01; // [RULE15]
		else if ((rank < cfg.fine) && !r.delayed)
			n.delayed = 1'b1; // [RULE21] [RULE16]
		else
		begin
			n.tick = 1'b1; // [RULE15]
			n.cnt = cfg.reload;
			n.delayed = 1'b0;
			n.slot = r.slot + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '0;
		else if (clk_en)
			r <= n;
	end
endmodule // uccb_baud_gen

// file: verif/uccb_remote_tx.sv
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module uccb_remote_tx
(
	input wire logic pclk,
	output logic line
);
	// Line rests high between frames
	initial line = 1'b1;

	// Bad flips the parity bit so a receive error can be provoked
	task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic odd, input logic bad);
		logic p;
		p = odd ^ bad;
		line <= 1'b0;
		repeat (16) @(posedge pclk);
		for (int i = 0; i < nb; i++)
		begin
			line <= d[i];
			p = p ^ d[i];
			repeat (16) @(posedge pclk);
		end
		if (pe)
		begin
			line <= p;
			repeat (16) @(posedge pclk);
		end
		line <= 1'b1;
		repeat (16) @(posedge pclk);
	endtask
endmodule // uccb_remote_tx

// file: verif/uccb_serial_port_chk.sv
// Port-level assertions for the serial port block
`timescale 1ns/1ps
module uccb_serial_port_chk
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [uccb_pkg::ADDR_W-1:0] paddr,
	input wire logic [uccb_pkg::DATA_W-1:0] pwdata,
	input wire logic [uccb_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_out_pin,
	input wire logic irq_tx_complete,
	input wire logic irq_rx_error,
	input wire logic irq_rx_full,
	input wire logic irq_tx_empty
);
	logic mapped;
	logic ctl_wr;
	assign mapped = (paddr[16:5] == 12'h820) && (paddr[1:0] == 2'b00);
	assign ctl_wr = psel && penable && pready && pwrite && (paddr == 17'h10410);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	property p_ready_wait; psel && !penable && clk_en |=> !pready ##1 pready; endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("pready not one wait state late");
	property p_err_map; pready |-> (pslverr == !mapped); endproperty
	a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
	property p_err_only; pslverr |-> pready; endproperty
	a_err_only: assert property (p_err_only) else $error("pslverr without pready");
	property p_prdata_upper; pready |-> (prdata[31:8] == 24'h000000); endproperty
	a_prdata_upper: assert property (p_prdata_upper) else $error("upper read bits not zero");
	property p_reset_quiet;
		$rose(presetn) |-> serial_out_pin && !pready && !irq_tx_complete && !irq_rx_error && !irq_rx_full && !irq_tx_empty;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
	property p_start_len; $fell(serial_out_pin) |-> !serial_out_pin [*8]; endproperty
	a_start_len: assert property (p_start_len) else $error("start bit too short");
	property p_disable_empties; ctl_wr && pwdata[4] && !pwdata[0] |-> ##[1:2] irq_tx_empty; endproperty
	a_disable_empties: assert property (p_disable_empties) else $error("buffer kept after disable");
	property p_enables_off;
		ctl_wr && (pwdata[7:4] == 4'h0) |-> ##1 (!irq_tx_complete && !irq_rx_error && !irq_rx_full && !irq_tx_empty) [*2];
	endproperty
	a_enables_off: assert property (p_enables_off) else $error("request without enable");
endmodule // uccb_serial_port_chk

bind uccb_serial_port uccb_serial_port_chk u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .serial_out_pin, .irq_tx_complete, .irq_rx_error, .irq_rx_full, .irq_tx_empty);

// file: verif/test_uart_config_control_baud.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ps
module test_uart_config_control_baud;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [16:0] paddr = 17'h00000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, serial_in_pin, serial_out_pin, err;
	logic irq_tx_complete, irq_rx_error, irq_rx_full, irq_tx_empty;
	int n_errors = 0;
	int comparisons = 0;
	int t;
	logic [7:0] fmts [5] = '{8'h00, 8'h1e, 8'h18, 8'h0a, 8'h04};
	logic [7:0] dats [5] = '{8'h35, 8'hb4, 8'hc5, 8'h53, 8'h2a};
	logic [7:0] masks [5] = '{8'h1e, 8'hf3, 8'h01, 8'hff, 8'h0f};

	uccb_serial_port u_uccb_serial_port (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .serial_in_pin, .serial_out_pin, .irq_tx_complete, .irq_rx_error,
		.irq_rx_full, .irq_tx_empty);
	uccb_remote_tx u_uccb_remote_tx (.pclk, .line(serial_in_pin));

	always #50 pclk = ~pclk;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Entered right after a rising edge; waits on pready, never a fixed count
	task xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		int w;
		w = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx[14:0], 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && w < 20)
		begin
			w++;
			@(posedge pclk);
		end
		if (w == 20)
			chk(32'h0, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task waitpin(input logic v);
		t = 0;
		while (serial_out_pin !== v && t < 3000)
		begin
			@(posedge pclk);
			t++;
		end
	endtask

	// Samples each bit in its middle; rate 0 gives sixteen cycles per bit
	task txframe(input logic [7:0] f, input logic [7:0] d);
		logic p;
		p = f[2];
		xfer(1'b1, uccb_pkg::IDX_TXDATA, {24'h0, d});
		waitpin(1'b0);
		repeat (8) @(posedge pclk);
		chk(serial_out_pin, 1'b0);
		for (int i = 0; i < (f[4] ? 8 : 7); i++)
		begin
			repeat (16) @(posedge pclk);
			chk(serial_out_pin, d[i]);
			p = p ^ d[i];
		end
		if (f[3])
		begin
			repeat (16) @(posedge pclk);
			chk(serial_out_pin, p);
		end
		for (int i = 0; i <= f[1]; i++)
		begin
			repeat (16) @(posedge pclk);
			chk(serial_out_pin, 1'b1);
		end
		repeat (20) @(posedge pclk);
		chk(irq_tx_complete, 1'b1);
	endtask

	task wrap_up;
		$display("Errors %0d, comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		#3000000;
		n_errors++;
		wrap_up;
	end

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, uccb_pkg::IDX_STATUS, 32'h0);
		chk(rd, 32'h01);
		for (int i = 0; i < 5; i++)
		begin
			xfer(1'b0, 16'(16'h4103 + i), 32'h0);
			chk(rd, 32'h0);
			xfer(1'b1, 16'(16'h4103 + i), 32'hffffffff);
			xfer(1'b0, 16'(16'h4103 + i), 32'h0);
			chk(rd, {24'h0, masks[i]});
			xfer(1'b1, 16'(16'h4103 + i), 32'h0);
		end
		xfer(1'b0, 16'h4108, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		for (int i = 0; i < 5; i++)
		begin
			xfer(1'b1, uccb_pkg::IDX_FORMAT, {24'h0, fmts[i]});
			xfer(1'b1, uccb_pkg::IDX_CTRL, 32'h81);
			txframe(fmts[i], dats[i]);
			xfer(1'b1, uccb_pkg::IDX_STATUS, 32'h80);
			xfer(1'b1, uccb_pkg::IDX_CTRL, 32'h00);
		end
		xfer(1'b1, uccb_pkg::IDX_FORMAT, 32'h1c);
		xfer(1'b1, uccb_pkg::IDX_CTRL, 32'h61);
		u_uccb_remote_tx.send(8'hc3, 8, 1'b1, 1'b1, 1'b0);
		repeat (20) @(posedge pclk);
		chk(irq_rx_full, 1'b1);
		xfer(1'b0, uccb_pkg::IDX_RXDATA, 32'h0);
		chk(rd, 32'hc3);
		xfer(1'b1, uccb_pkg::IDX_CTRL, 32'h00);
		xfer(1'b1, uccb_pkg::IDX_FORMAT, 32'h08);
		xfer(1'b1, uccb_pkg::IDX_CTRL, 32'h63);
		u_uccb_remote_tx.send(8'hff, 7, 1'b1, 1'b0, 1'b0);
		repeat (20) @(posedge pclk);
		chk({irq_rx_full, irq_rx_error}, 2'b00);
		u_uccb_remote_tx.send(8'h81, 7, 1'b1, 1'b0, 1'b1);
		repeat (20) @(posedge pclk);
		chk({irq_rx_full, irq_rx_error}, 2'b11);
		xfer(1'b0, uccb_pkg::IDX_STATUS, 32'h0);
		chk(rd, 32'h2b);
		// Third character with both slots full must be dropped
		u_uccb_remote_tx.send(8'h00, 7, 1'b1, 1'b0, 1'b0);
		repeat (20) @(posedge pclk);
		xfer(1'b0, uccb_pkg::IDX_STATUS, 32'h0);
		chk(rd, 32'h3b);
		xfer(1'b0, uccb_pkg::IDX_RXDATA, 32'h0);
		chk(rd, 32'h7f);
		xfer(1'b0, uccb_pkg::IDX_RXDATA, 32'h0);
		chk(rd, 32'h01);
		xfer(1'b1, uccb_pkg::IDX_STATUS, 32'h30);
		chk({irq_rx_full, irq_rx_error}, 2'b00);
		xfer(1'b1, uccb_pkg::IDX_CTRL, 32'h00);
		xfer(1'b1, uccb_pkg::IDX_RATE, 32'h02);
		xfer(1'b1, uccb_pkg::IDX_FINE, 32'h05);
		xfer(1'b1, uccb_pkg::IDX_FORMAT, 32'h10);
		xfer(1'b1, uccb_pkg::IDX_CTRL, 32'h01);
		xfer(1'b1, uccb_pkg::IDX_TXDATA, 32'h00);
		waitpin(1'b0);
		waitpin(1'b1);
		chk(t, 9 * (16 * 3 + 5));
		// Clock enable low must hold the start bit well past its length
		xfer(1'b1, uccb_pkg::IDX_TXDATA, 32'hff);
		waitpin(1'b0);
		clk_en <= 1'b0;
		repeat (200) @(posedge pclk);
		chk(serial_out_pin, 1'b0);
		clk_en <= 1'b1;
		@(posedge pclk);
		xfer(1'b1, uccb_pkg::IDX_CTRL, 32'h00);
		xfer(1'b1, uccb_pkg::IDX_RATE, 32'h00);
		xfer(1'b1, uccb_pkg::IDX_FINE, 32'h00);
		xfer(1'b1, uccb_pkg::IDX_CTRL, 32'h01);
		xfer(1'b1, uccb_pkg::IDX_TXDATA, 32'h55);
		xfer(1'b1, uccb_pkg::IDX_TXDATA, 32'haa);
		xfer(1'b1, uccb_pkg::IDX_CTRL, 32'h10);
		xfer(1'b0, uccb_pkg::IDX_STATUS, 32'h0);
		chk(rd & 32'h05, 32'h01);
		chk(irq_tx_empty, 1'b1);
		xfer(1'b1, uccb_pkg::IDX_CTRL, 32'h01);
		repeat (100) @(posedge pclk);
		chk(serial_out_pin, 1'b1);
		xfer(1'b1, uccb_pkg::IDX_CTRL, 32'h00);
		xfer(1'b1, uccb_pkg::IDX_IRSEL, 32'h01);
		repeat (4) @(posedge pclk);
		chk(serial_out_pin, 1'b0);
		xfer(1'b1, uccb_pkg::IDX_IRSEL, 32'h00);
		repeat (4) @(posedge pclk);
		chk(serial_out_pin, 1'b1);
		wrap_up;
	end
endmodule // test_uart_config_control_baud
